// ==== design/io_bus_master.sv ====
// i/o bus master: pended read returns, guest read grants, direct i/o writes
// assumes queues upstream present data with valid/ready, guests follow the bus protocol
// Operation
// - read returns win over all other traffic except higher_req
// - accept pended request right after return
// - follow-on grant needs early request, no higher
// - pended read request takes four cycles, three as a follow-on
// - fixed writes: one word or two words
// - variable writes carry one to eight words
// - beat mode single or double word
// - fast one-word write two cycles, else three
// - writes may follow back to back unlimited
// - fastest timing needs same target, fast ack
// - returns arbitrate like any master
module io_bus_master (
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   input  wire io_bus_pkg::read_ret_s       ret_cmd,
   input  wire logic                        ret_valid,
   output logic                             ret_ready,
   input  wire io_bus_pkg::write_cmd_s      wr_cmd,
   input  wire logic                        wr_valid,
   output logic                             wr_ready,
   input  wire logic [io_bus_pkg::GUEST_N-1:0] guest_req,
   input  wire logic                        higher_req,
   input  wire logic                        write_ack_n,
   output logic [io_bus_pkg::GUEST_N-1:0]   guest_grant,
   output logic                             bus_addr_valid,
   output logic [io_bus_pkg::WORD_W-1:0]    bus_addr,
   output logic                             bus_data_valid,
   output logic                             bus_double_beat,
   output logic                             bus_last,
   output logic                             ret_active,
   output logic                             variable_length_write
);
   import io_bus_pkg::*;

   typedef struct packed {
      bus_state_e          st;
      logic                is_ret;
      logic                dbl;
      logic                wait_ack;
      logic [LEN_W-1:0]    beats;
      logic [GID_W-1:0]    target;
      logic [GUEST_N-1:0]  grant;
      logic [1:0]          gcnt;
      logic                follow;
      logic [GID_W-1:0]    fgid;
      logic                av;
      logic [WORD_W-1:0]   addr;
      logic                dv;
      logic                last;
      logic                vlw;
      logic                rr;
      logic                wr;
      logic                act;         // return tenure on the bus
   } state_s;

   state_s s_reg, s_next;

   // payload length forced into 1..8 words so the beat counter never wraps
   function automatic logic [LEN_W-1:0] clamp_words(input logic [LEN_W-1:0] n);
      clamp_words = (n == 4'h0) ? MIN_WORDS : ((n > MAX_WORDS) ? MAX_WORDS : n);
   endfunction

   // beats a write needs after its address cycle
   function automatic logic [LEN_W-1:0] beat_count(input write_cmd_s c);
      logic [LEN_W-1:0] w;
      w = clamp_words(c.words);
      unique case (c.kind)
         WR_FIXED_ONE: beat_count = c.fast ? 4'h1 : 4'h2;
         WR_FIXED_TWO: beat_count = 4'h2;
         default:      beat_count = c.double_beat ? ((w + 4'h1) >> 1) : w;
      endcase
   endfunction

   // lowest-numbered requesting guest
   function automatic logic [GID_W-1:0] first_req(input logic [GUEST_N-1:0] r);
      first_req = '0;
      for (int i = GUEST_N - 1; i >= 0; i--) begin
         if (r[i]) begin
            first_req = GID_W'(i);
         end
      end
   endfunction

   // next-state logic; one path per bus tenure
   always_comb begin
      s_next     = s_reg;
      s_next.av  = 1'b0;
      s_next.dv  = 1'b0;
      s_next.last = 1'b0;
      s_next.rr  = 1'b0;
      s_next.wr  = 1'b0;
      unique case (s_reg.st)
         ST_IDLE: begin
            // returns take the bus first, after arbitration like anyone else
            if (ret_valid && !higher_req) begin
               s_next.st     = ST_ADDR;
               s_next.is_ret = 1'b1;
               s_next.dbl    = 1'b0;
               s_next.beats  = clamp_words(ret_cmd.words);
               s_next.target = ret_cmd.target;
               s_next.addr   = '0;
               s_next.rr     = 1'b1;
            end else if (s_reg.follow && guest_req[s_reg.fgid] && !higher_req) begin
               s_next.st     = ST_GUEST;
               s_next.grant  = GUEST_N'(1) << s_reg.fgid;
               s_next.gcnt   = GRANT_DLY;
               s_next.follow = 1'b0;
            end else if (wr_valid && !higher_req) begin
               s_next.st     = ST_ADDR;
               s_next.is_ret = 1'b0;
               s_next.dbl    = (wr_cmd.kind == WR_VARIABLE) && wr_cmd.double_beat;
               s_next.beats  = beat_count(wr_cmd);
               s_next.wait_ack = (wr_cmd.target != s_reg.target);
               s_next.target = wr_cmd.target;
               s_next.addr   = wr_cmd.addr;
               s_next.vlw    = (wr_cmd.kind == WR_VARIABLE);
               s_next.wr     = 1'b1;
            end else if ((guest_req != '0) && !higher_req) begin
               s_next.st     = ST_ARB;                                        // internal grant delay
               s_next.fgid   = first_req(guest_req);
               s_next.follow = 1'b0;
            end
         end
         ST_ARB: begin
            s_next.st    = ST_GUEST;
            s_next.grant = GUEST_N'(1) << s_reg.fgid;
            s_next.gcnt  = GRANT_DLY;
         end
         ST_ADDR: begin
            s_next.st = ST_DATA;
            s_next.av = 1'b1;
         end
         ST_DATA: begin
            // change of target holds the first beat until the guest acks
            if (!s_reg.wait_ack || !write_ack_n) begin
               s_next.wait_ack = 1'b0;
               s_next.dv    = 1'b1;
               s_next.beats = s_reg.beats - 4'h1;
               if (s_reg.beats == 4'h1) begin
                  s_next.last = 1'b1;
                  s_next.st   = ST_IDLE;
                  s_next.vlw  = 1'b0;
                  // request raised before the final beat earns a follow-on grant
                  if (s_reg.is_ret) begin
                     s_next.follow = guest_req[s_reg.target];
                     s_next.fgid   = s_reg.target;
                  end
               end
            end
         end
         ST_GUEST: begin
            // guest owns the bus for its address cycle, then lets go
            if (s_reg.gcnt != 2'h0) begin
               s_next.gcnt = s_reg.gcnt - 2'h1;
            end else begin
               s_next.grant = GRANT_RST;
               s_next.st    = ST_TURN;
            end
         end
         ST_TURN: begin
            s_next.st = ST_IDLE;
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase
      // registered so the pin is flop-driven; guest tenures keep is_ret, so match states
      s_next.act = s_next.is_ret && ((s_next.st == ST_ADDR) || (s_next.st == ST_DATA));
   end

   // single state register; all outputs come from it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_reg <= '{st: ST_IDLE, grant: GRANT_RST, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign ret_ready             = s_reg.rr;
   assign wr_ready              = s_reg.wr;
   assign guest_grant           = s_reg.grant;
   assign bus_addr_valid        = s_reg.av;
   assign bus_addr              = s_reg.addr;
   assign bus_data_valid        = s_reg.dv;
   assign bus_double_beat       = s_reg.dbl;
   assign bus_last              = s_reg.last;
   assign ret_active            = s_reg.act;
   assign variable_length_write = s_reg.vlw;

   // a guest tenure spans arb, two grant cycles and turn: four cycles from idle
   sequence seq_arb;
      s_reg.st == ST_ARB;
   endsequence
   sequence seq_grant_turn;
      (s_reg.st == ST_GUEST) [*2] ##1 (s_reg.st == ST_TURN);
   endsequence

   AST_RET_FIRST: assert property (@(posedge core_clk) disable iff (rst)
      (s_reg.st == ST_IDLE && ret_valid && !higher_req) |=> s_reg.rr)
      else $error("read return not taken first");
   AST_NO_WR_WITH_RET: assert property (@(posedge core_clk) disable iff (rst)
      (s_reg.st == ST_IDLE && ret_valid) |=> !s_reg.wr)
      else $error("write taken over pending return");
   AST_REQ_LEN: assert property (@(posedge core_clk) disable iff (rst)
      seq_arb |=> seq_grant_turn ##1 (s_reg.st == ST_IDLE))
      else $error("pended request tenure length wrong");
   AST_FOLLOW: assert property (@(posedge core_clk) disable iff (rst)
      (s_reg.st == ST_IDLE && s_reg.follow && guest_req[s_reg.fgid] && !ret_valid && !higher_req)
      |=> (s_reg.st == ST_GUEST) && s_reg.grant[s_reg.fgid])
      else $error("follow-on request not granted");
   AST_HIGHER: assert property (@(posedge core_clk) disable iff (rst)
      (s_reg.st == ST_IDLE && higher_req) |=> (s_reg.st == ST_IDLE))
      else $error("bus taken while higher module requests");
   AST_GRANT_ONE: assert property (@(posedge core_clk) disable iff (rst)
      $onehot0(s_reg.grant))
      else $error("more than one grant");
   AST_FAST_ONE: assert property (@(posedge core_clk) disable iff (rst)
      (s_reg.st == ST_IDLE && !ret_valid && !(s_reg.follow && guest_req[s_reg.fgid]) && wr_valid
       && !higher_req && wr_cmd.kind == WR_FIXED_ONE && wr_cmd.fast && wr_cmd.target == s_reg.target)
      |=> ##1 s_reg.av ##1 (s_reg.dv && s_reg.last))
      else $error("fast single word write not two bus cycles");
   AST_TWO_WORD: assert property (@(posedge core_clk) disable iff (rst)
      (s_reg.st == ST_IDLE && !ret_valid && !(s_reg.follow && guest_req[s_reg.fgid]) && wr_valid
       && !higher_req && wr_cmd.kind == WR_FIXED_TWO && wr_cmd.target == s_reg.target)
      |=> ##1 s_reg.av ##1 (s_reg.dv && !s_reg.last) ##1 (s_reg.dv && s_reg.last))
      else $error("two word write not three bus cycles");
   AST_BEATS_MAX: assert property (@(posedge core_clk) disable iff (rst)
      (s_reg.st == ST_DATA) |-> (s_reg.beats <= MAX_WORDS && s_reg.beats != 4'h0))
      else $error("beat count out of range");
   AST_LAST_IDLE: assert property (@(posedge core_clk) disable iff (rst)
      s_reg.last |-> (s_reg.dv && s_reg.st == ST_IDLE))
      else $error("last beat without end of tenure");
endmodule // io_bus_master

// ==== design/io_bus_pkg.sv ====
// constants and carrier structs for the i/o bus master
// assumes one core clock, synchronous reset, all inputs synchronous
package io_bus_pkg;
   localparam int  WORD_W           = 32;
   localparam int  GUEST_N          = 8;
   localparam int  GID_W            = 3;
   localparam int  LEN_W            = 4;      // words 1..8
   localparam logic [3:0] MAX_WORDS = 4'h8;
   localparam logic [3:0] MIN_WORDS = 4'h1;
   localparam logic [3:0] FIXED_TWO = 4'h2;   // 8-byte fixed write
   localparam logic [1:0] GRANT_DLY = 2'h1;   // extra cycles the grant is held
   localparam logic [2:0] READ_REQ_CYC = 3'h3; // bus cycles per follow-on pended read request
   localparam logic [GUEST_N-1:0] GRANT_RST = 8'h00;

   typedef enum logic [1:0] {
      WR_FIXED_ONE      = 2'h0,
      WR_FIXED_TWO      = 2'h1,
      WR_VARIABLE       = 2'h2
   } write_kind_e;

   // direct i/o write command from the outbound queue
   typedef struct packed {
      write_kind_e        kind;
      logic               fast;          // fast timing for single word
      logic               double_beat;   // double_word_beat_mode when set
      logic [LEN_W-1:0]   words;
      logic [GID_W-1:0]   target;
      logic [WORD_W-1:0]  addr;
   } write_cmd_s;

   // pended read return from the return queue
   typedef struct packed {
      logic [LEN_W-1:0]   words;
      logic [GID_W-1:0]   target;
   } read_ret_s;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_ARB   = 6'b000010,
      ST_ADDR  = 6'b000100,
      ST_DATA  = 6'b001000,
      ST_TURN  = 6'b010000,
      ST_GUEST = 6'b100000
   } bus_state_e;
endpackage : io_bus_pkg

// ==== verif/guest_model.sv ====
// guest side of the i/o bus: bus requests and write acknowledge
// assumes the master's grant and address strobes are registered on core_clk
module guest_model (
   input  wire logic                           core_clk,
   input  wire logic                           rst,
   input  wire logic [io_bus_pkg::GUEST_N-1:0] ask,
   input  wire logic [io_bus_pkg::GUEST_N-1:0] guest_grant,
   input  wire logic                           bus_addr_valid,
   input  wire logic                           bus_last,
   output logic      [io_bus_pkg::GUEST_N-1:0] guest_req,
   output logic                                write_ack_n
);
   timeunit 1ns;
   timeprecision 1ps;
   import io_bus_pkg::*;
   // one request held per guest until granted dropped in the address cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         guest_req   <= '0;
         write_ack_n <= 1'b1;
      end else begin
         guest_req <= (guest_req | ask) & ~guest_grant;
         // ack a cycle after the address, idle high like a pulled-up line
         if (bus_addr_valid)
            write_ack_n <= 1'b0;
         else if (bus_last)
            write_ack_n <= 1'b1;
      end
   end
endmodule // guest_model

// ==== verif/tb_top.sv ====
// bench for io_bus_master: returns, guest grants and direct i/o writes
// assumes a guest_model on the far side; outputs sampled at falling edges
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import io_bus_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, ret_valid = 1'b0, wr_valid = 1'b0, higher_req = 1'b0;
   logic ret_ready, wr_ready, write_ack_n, bus_addr_valid, bus_data_valid, bus_double_beat;
   logic bus_last, ret_active, variable_length_write;
   read_ret_s          ret_cmd = '0;
   write_cmd_s         wr_cmd  = '0;
   logic [GUEST_N-1:0] ask = '0, guest_req, guest_grant;
   logic [WORD_W-1:0]  bus_addr;
   int                 n_errors = 0, n_tests = 0;
   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;
   io_bus_master dut (.core_clk(core_clk), .rst(rst), .ret_cmd(ret_cmd), .ret_valid(ret_valid),
      .ret_ready(ret_ready), .wr_cmd(wr_cmd), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .guest_req(guest_req), .higher_req(higher_req), .write_ack_n(write_ack_n),
      .guest_grant(guest_grant), .bus_addr_valid(bus_addr_valid), .bus_addr(bus_addr),
      .bus_data_valid(bus_data_valid), .bus_double_beat(bus_double_beat), .bus_last(bus_last),
      .ret_active(ret_active), .variable_length_write(variable_length_write));
   guest_model guest (.core_clk(core_clk), .rst(rst), .ask(ask), .guest_grant(guest_grant),
      .bus_addr_valid(bus_addr_valid), .bus_last(bus_last), .guest_req(guest_req),
      .write_ack_n(write_ack_n));
   task automatic stop_test();
      $display("tests=%0d errors=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic pick(input int w);
      case (w)
         0: return wr_ready;
         1: return ret_ready;
         2: return bus_last;
         3: return |guest_grant;
         default: return ret_ready | wr_ready;
      endcase
   endfunction
   // bounded wait for a strobe, counting data beats on the way; a hang ends the run
   task automatic wait_for(input int w, output int beats);
      beats = 0;
      for (int i = 0; i < 60; i++) begin
         @(negedge core_clk);
         beats += bus_data_valid;
         if (pick(w) === 1'b1) return;
      end
      n_errors++;
      stop_test();
   endtask
   // one write: hold valid until popped, then count beats to the last one
   task automatic do_write(input write_kind_e k, input logic f, input logic d, input logic [3:0] w,
                           input int exp);
      int b;
      wr_cmd   = '{kind: k, fast: f, double_beat: d, words: w, target: 3'h1, addr: 32'h0000_1000};
      wr_valid = 1'b1;
      wait_for(0, b);
      wr_valid = 1'b0;
      check(variable_length_write, k == WR_VARIABLE);
      wait_for(2, b);
      check(b, exp);
      check(variable_length_write, 1'b0);
      if (k == WR_VARIABLE) check(bus_double_beat, d);
   endtask
   // return and write offered together: the return goes first, the write waits
   task automatic t_priority();
      int b;
      ret_cmd   = '{words: 4'h2, target: 3'h3};
      ret_valid = 1'b1;
      wr_cmd    = '{kind: WR_FIXED_TWO, fast: 1'b0, double_beat: 1'b0, words: 4'h2, target: 3'h1,
                    addr: 32'h0000_3000};
      wr_valid  = 1'b1;
      wait_for(4, b);
      ret_valid = 1'b0;
      check(ret_ready, 1'b1);
      check(wr_ready, 1'b0);
      check(ret_active, 1'b1);
      wait_for(2, b);
      check(b, 2);
      check(ret_active, 1'b0);
      wait_for(0, b);
      wr_valid = 1'b0;
      wait_for(2, b);
      check(b, 2);
      check(bus_addr, 32'h0000_3000);
   endtask
   // a higher module holds the bus off; nothing is taken meanwhile
   task automatic t_higher();
      int b;
      higher_req = 1'b1;
      ret_valid  = 1'b1;
      repeat (8) begin
         @(negedge core_clk);
         check(ret_ready, 1'b0);
      end
      higher_req = 1'b0;
      wait_for(1, b);
      ret_valid = 1'b0;
      wait_for(2, b);
   endtask
   // early request by the return's target wins over a lower-index guest
   task automatic t_follow();
      int b, n;
      ret_cmd   = '{words: 4'h4, target: 3'h2};
      ret_valid = 1'b1;
      wait_for(1, b);
      ret_valid = 1'b0;
      ask       = 8'h05;
      @(negedge core_clk);
      ask = 8'h00;
      wait_for(2, b);
      wait_for(3, b);
      check(guest_grant, 8'h04);
      check(ret_active, 1'b0);
      for (n = 0; n < 9 && guest_grant !== 8'h00; n++) @(negedge core_clk);
      check(n, 2);
      wait_for(3, b);
      check(guest_grant, 8'h01);
   endtask
   // writes offered without a gap are all taken in turn
   task automatic t_burst();
      int b;
      wr_cmd   = '{kind: WR_FIXED_ONE, fast: 1'b1, double_beat: 1'b0, words: 4'h1, target: 3'h1,
                   addr: 32'h0000_2000};
      wr_valid = 1'b1;
      repeat (4) wait_for(0, b);
      wr_valid = 1'b0;
      wait_for(2, b);
      check(bus_addr, 32'h0000_2000);
   endtask
   initial begin
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      @(negedge core_clk);
      check({ret_ready, wr_ready, bus_addr_valid, guest_grant}, 32'h0);
      do_write(WR_FIXED_ONE, 1'b1, 1'b0, 4'h1, 1);
      do_write(WR_FIXED_ONE, 1'b0, 1'b0, 4'h1, 2);
      do_write(WR_FIXED_TWO, 1'b0, 1'b0, 4'h2, 2);
      for (int w = 1; w <= 8; w++)
         for (int d = 0; d < 2; d++)
            do_write(WR_VARIABLE, 1'b0, d[0], w[3:0], (d != 0) ? (w + 1) / 2 : w);
      t_priority();
      t_higher();
      t_follow();
      t_burst();
      stop_test();
   end
endmodule // tb_top
